// ===== hdl/ubf_uart_core.sv
// uart baud generator, 4-byte receive fifo, single-wire pin control
// assumes wishbone classic master, inputs synchronous to i_core_clk
//
// What this block does
// - single-wire off: shared pin only receives; on: rx/tx per enable bits
// - single-wire with both enables high: shared pin only receives, never drives
// - tx and rx invert bits reset to 0; set inverts that line
// - one 8-bit data register: writes load a transmit holding byte that nothing sends, reads return received bytes
// - bit rate is clock over divisor plus modulation/8
// - bit timing from a 16-bit timer that runs only while a frame is received, set by divisor and modulation
// - modulation added per bit; carry into bit 3 lengthens bit by one clock
// - range select 0: sample at div/2, div/2+1, div/2+2
// - range select 1: sample at div/2-1, div/2, div/2+2
// - trigger code 00 four, 01 one, 10 two, 11 three bytes
// - trigger-raised ready flag with interrupt enable raises the irq
// - receive fifo holds four bytes, empty after reset
// - fill counter rises on fifo entry, falls on software read
// - fifo full: fifth byte kept in held slot, sixth replaces it, count 4
// - fill counter cleared by reset and whenever the unit-enable bit is low
// - disabling empties buffer, clears counter, keeps divisor and fifo settings
// - with irq enable, overrun or ready sets irq; without, neither does
`timescale 1ns/1ps

module ubf_uart_core #(
  parameter int DEPTH = ubf_pkg::UBF_FIFO_DEPTH
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  input  wire ubf_pkg::ubf_wb_req_t i_wb,
  output logic                    o_wb_ack,
  output logic [31:0]             o_wb_dat,
  input  wire logic               i_shared_pin,
  output logic                    o_shared_pin,
  output logic                    o_shared_pin_oe,
  output logic                    o_transmit_pin,
  output logic                    o_irq
);
  import ubf_pkg::*;

  // ---------------------------------------------------------------
  // parameter check: pointers and counter are sized for four slots
  // ---------------------------------------------------------------
  if (DEPTH != 4) begin : g_depth_check
    $error("ubf_uart_core: fifo depth must be 4");
  end

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_reg <= 2'b00;
    else          rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  logic           access, wr, rd;
  ubf_line_mode_t line_mode_reg;
  ubf_fifo_mod_t  fifo_mod_reg;
  logic [7:0]     div_high_reg, div_low_reg, tx_data_reg;
  logic [3:0]     control_reg;
  logic           unit_enable, rx_en, tx_en, rx_irq_enable;
  assign access = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign wr     = access && i_wb.we && i_wb.sel[0];
  assign rd     = access && !i_wb.we;
  assign unit_enable   = control_reg[UBF_CT_UEN_BIT];
  assign rx_en         = control_reg[UBF_CT_RECEIVER_ENABLE_BIT_BIT];
  assign tx_en         = control_reg[UBF_CT_TRANSMITTER_ENABLE_BIT_BIT];
  assign rx_irq_enable = control_reg[UBF_CT_RIE_BIT];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // configuration survives disable
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_mode_reg <= UBF_LINE_MODE_RST;
      fifo_mod_reg  <= UBF_FIFO_MOD_RST;
      div_high_reg  <= UBF_DIV_RST;
      div_low_reg   <= UBF_DIV_RST;
      control_reg   <= UBF_CONTROL_RST;
    end else if (i_ce && wr) begin
      if (hit(i_wb.adr, UBF_OFS_LINE_MODE)) line_mode_reg <= i_wb.dat[2:0];
      if (hit(i_wb.adr, UBF_OFS_FIFO_MOD))  fifo_mod_reg  <= i_wb.dat[5:0];
      if (hit(i_wb.adr, UBF_OFS_DIV_HIGH))  div_high_reg  <= i_wb.dat[7:0];
      if (hit(i_wb.adr, UBF_OFS_DIV_LOW))   div_low_reg   <= i_wb.dat[7:0];
      if (hit(i_wb.adr, UBF_OFS_CONTROL))   control_reg   <= i_wb.dat[3:0];
    end
  end

  // transmit byte holding; content is not defined by reset
  always_ff @(posedge i_core_clk) begin
    if (i_ce && wr && hit(i_wb.adr, UBF_OFS_DATA)) tx_data_reg <= i_wb.dat[7:0];
  end

  // ---------------------------------------------------------------
  // baud timer with fractional accumulator
  // ---------------------------------------------------------------
  logic [15:0] divisor, half, bit_cnt_reg, period_end;
  logic [2:0]  mod_acc_reg;
  logic [3:0]  mod_sum;
  logic        bit_end, timer_run;
  assign divisor    = {div_high_reg, div_low_reg};
  assign half       = {1'b0, divisor[15:1]};
  assign mod_sum    = {1'b0, mod_acc_reg} + {1'b0, fifo_mod_reg.fraction_adjust};
  // the carry of this bit's own addition stretches this same bit
  assign period_end = mod_sum[3] ? divisor : divisor - 16'h0001;
  assign bit_end    = timer_run && (bit_cnt_reg >= period_end);

  // bit timer, cleared while the receiver is idle, one bit per divisor (+1) clocks
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 16'h0000;
      mod_acc_reg <= 3'h0;
    end else if (i_ce) begin
      if (!timer_run) begin
        bit_cnt_reg <= 16'h0000;
        mod_acc_reg <= 3'h0;
      end else if (bit_end) begin
        bit_cnt_reg <= 16'h0000;
        mod_acc_reg <= mod_sum[2:0];
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // receiver: start detect, three samples, majority vote
  // ---------------------------------------------------------------
  ubf_rx_state_t rx_state_reg;
  logic [2:0]    samp_reg;
  logic [3:0]    rx_bit_idx_reg;
  logic [7:0]    rx_shift_reg;
  logic          rx_line, pin_is_rx, voted, byte_done_reg, sample_now;
  logic [1:0]    samp_idx;
  logic [15:0]   s0, s1, s2;

  // shared pin receives unless single-wire transmit-only
  assign pin_is_rx = !line_mode_reg.single_wire_enable || rx_en || !tx_en;
  assign rx_line   = (pin_is_rx ? i_shared_pin : 1'b1) ^ line_mode_reg.rx_invert;
  assign timer_run = unit_enable && rx_en && (rx_state_reg != UBF_RX_IDLE);

  // start is seen one clock late; all three samples still land inside the bit
  // sample points by range select
  always_comb begin
    s0 = fifo_mod_reg.divisor_range_select ? half - 16'h0001 : half;
    s1 = fifo_mod_reg.divisor_range_select ? half : half + 16'h0001;
    s2 = half + 16'h0002;
    samp_idx = 2'd3;
    if (bit_cnt_reg == s0) samp_idx = 2'd0;
    if (bit_cnt_reg == s1) samp_idx = 2'd1;
    if (bit_cnt_reg == s2) samp_idx = 2'd2;
    sample_now = timer_run && (samp_idx != 2'd3);
  end

  // majority of the three samples
  assign voted = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2])
               | (samp_reg[1] & samp_reg[2]);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg   <= UBF_RX_IDLE;
      samp_reg       <= 3'h7;
      rx_bit_idx_reg <= 4'h0;
      rx_shift_reg   <= 8'h00;
      byte_done_reg  <= 1'b0;
    end else if (i_ce) begin
      byte_done_reg <= 1'b0;
      if (sample_now) samp_reg[samp_idx] <= rx_line;
      if (!unit_enable || !rx_en) begin
        rx_state_reg <= UBF_RX_IDLE;
      end else begin
        case (rx_state_reg)
          UBF_RX_IDLE: begin
            if (!rx_line) rx_state_reg <= UBF_RX_START;
          end
          UBF_RX_START: begin
            if (bit_end) begin
              rx_state_reg   <= voted ? UBF_RX_IDLE : UBF_RX_BITS;
              rx_bit_idx_reg <= 4'h0;
            end
          end
          UBF_RX_BITS: begin
            if (bit_end) begin
              if (rx_bit_idx_reg == 4'h8) begin
                rx_state_reg  <= UBF_RX_IDLE;
                byte_done_reg <= voted;
              end else begin
                rx_shift_reg   <= {voted, rx_shift_reg[7:1]};
                rx_bit_idx_reg <= rx_bit_idx_reg + 4'h1;
              end
            end
          end
          default: rx_state_reg <= UBF_RX_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // receive fifo, held-byte slot, counter and flags
  // ---------------------------------------------------------------
  logic [7:0] fifo_mem_reg [DEPTH];
  logic [1:0] wr_ptr_reg, rd_ptr_reg;
  logic [2:0] fill_cnt_reg;
  logic [7:0] held_reg;
  logic       held_valid_reg, overrun_reg, rx_ready, pop, push, full;
  assign full = (fill_cnt_reg == 3'(DEPTH));
  assign pop  = rd && hit(i_wb.adr, UBF_OFS_DATA) && (fill_cnt_reg != 3'h0) && i_ce;
  assign push = byte_done_reg && i_ce;

  always_ff @(posedge i_core_clk) begin
    if (push && !full) fifo_mem_reg[wr_ptr_reg] <= rx_shift_reg;
    else if (pop && held_valid_reg) fifo_mem_reg[wr_ptr_reg] <= held_reg;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg     <= 2'h0;
      rd_ptr_reg     <= 2'h0;
      fill_cnt_reg   <= 3'h0;
      held_valid_reg <= 1'b0;
      held_reg       <= 8'h00;
      overrun_reg    <= 1'b0;
    end else if (i_ce) begin
      if (!unit_enable) begin
        wr_ptr_reg     <= 2'h0;
        rd_ptr_reg     <= 2'h0;
        fill_cnt_reg   <= 3'h0;
        held_valid_reg <= 1'b0;
        overrun_reg    <= 1'b0;
      end else begin
        if (pop) rd_ptr_reg <= rd_ptr_reg + 2'h1;
        if (push && !full) begin
          wr_ptr_reg <= wr_ptr_reg + 2'h1;
          if (!pop) fill_cnt_reg <= fill_cnt_reg + 3'h1;
        end else if (push && full) begin
          held_reg       <= rx_shift_reg;
          held_valid_reg <= 1'b1;
          if (held_valid_reg) overrun_reg <= 1'b1;
        end else if (pop && held_valid_reg) begin
          wr_ptr_reg     <= wr_ptr_reg + 2'h1;
          held_valid_reg <= 1'b0;
        end else if (pop) begin
          fill_cnt_reg <= fill_cnt_reg - 3'h1;
        end
        if (rd && hit(i_wb.adr, UBF_OFS_STATUS) && !(push && full && held_valid_reg))
          overrun_reg <= 1'b0;
      end
    end
  end

  // trigger decode
  always_comb begin
    case (fifo_mod_reg.rx_trigger_level)
      2'b00:   rx_ready = (fill_cnt_reg >= 3'h4);
      2'b01:   rx_ready = (fill_cnt_reg >= 3'h1);
      2'b10:   rx_ready = (fill_cnt_reg >= 3'h2);
      2'b11:   rx_ready = (fill_cnt_reg >= 3'h3);
      default: rx_ready = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_wb.adr)
      UBF_OFS_LINE_MODE: rd_mux = {29'h0, line_mode_reg};
      UBF_OFS_DATA:      rd_mux = {24'h0, fifo_mem_reg[rd_ptr_reg]};
      UBF_OFS_DIV_HIGH:  rd_mux = {24'h0, div_high_reg};
      UBF_OFS_DIV_LOW:   rd_mux = {24'h0, div_low_reg};
      UBF_OFS_FIFO_MOD:  rd_mux = {26'h0, fifo_mod_reg};
      UBF_OFS_FILL_CNT:  rd_mux = {29'h0, fill_cnt_reg};
      UBF_OFS_CONTROL:   rd_mux = {28'h0, control_reg};
      UBF_OFS_STATUS:    rd_mux = {30'h0, overrun_reg, rx_ready};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack        <= 1'b0;
      o_wb_dat        <= 32'h0000_0000;
      o_irq           <= 1'b0;
      o_shared_pin    <= 1'b1;
      o_shared_pin_oe <= 1'b0;
      o_transmit_pin  <= 1'b1;
    end else if (i_ce) begin
      o_wb_ack <= access;
      if (rd) o_wb_dat <= rd_mux;
      o_irq <= rx_irq_enable && (rx_ready || overrun_reg);
      // idle-high transmit line, inverted on request
      o_transmit_pin  <= 1'b1 ^ line_mode_reg.tx_invert;
      o_shared_pin    <= 1'b1 ^ line_mode_reg.tx_invert;
      o_shared_pin_oe <= unit_enable && line_mode_reg.single_wire_enable
                         && tx_en && !rx_en;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_pin_never_both: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (line_mode_reg.single_wire_enable && rx_en && tx_en && i_ce) |=> !o_shared_pin_oe)
    else $error("shared pin driven with both enables");
  a_pin_rx_only: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !line_mode_reg.single_wire_enable |=> !o_shared_pin_oe)
    else $error("shared pin driven outside single-wire mode");
  a_count_max_four: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    fill_cnt_reg <= 3'h4) else $error("fill counter above four");
  a_count_clear_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!unit_enable && i_ce) |=> fill_cnt_reg == 3'h0) else $error("counter not cleared");
  a_count_push_up: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (push && !full && !pop && unit_enable) |=> fill_cnt_reg == $past(fill_cnt_reg) + 3'h1)
    else $error("counter did not rise");
  a_count_pop_down: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (pop && !push && !held_valid_reg && unit_enable)
    |=> fill_cnt_reg == $past(fill_cnt_reg) - 3'h1) else $error("counter did not fall");
  a_irq_gate: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && !rx_irq_enable) |=> !o_irq) else $error("irq without enable");
  a_irq_ready: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && rx_irq_enable && rx_ready) |=> o_irq) else $error("ready did not raise irq");
  a_overrun_set: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (push && full && held_valid_reg && unit_enable) |=> overrun_reg)
    else $error("overrun not flagged");
  a_bit_length: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (bit_end && i_ce && timer_run)
    |-> bit_cnt_reg == (mod_sum[3] ? divisor : divisor - 16'h0001))
    else $error("bit period wrong");
  a_oe_single_tx: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && unit_enable && line_mode_reg.single_wire_enable && tx_en && !rx_en)
    |=> o_shared_pin_oe) else $error("shared pin not driven for single-wire transmit");
  a_tx_idle_level: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_ce |=> (o_transmit_pin == !$past(line_mode_reg.tx_invert)))
    else $error("transmit idle level wrong");
  a_ce_freeze: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !i_ce |=> ($stable(fill_cnt_reg) && $stable(control_reg) && $stable(o_wb_ack)
               && $stable(o_irq))) else $error("state moved with clock enable low");
  a_disable_clears: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!unit_enable && i_ce) |=> (!held_valid_reg && !overrun_reg))
    else $error("disable left held byte or overrun");
  a_irq_overrun: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && rx_irq_enable && overrun_reg) |=> o_irq)
    else $error("overrun did not raise irq");
  a_full_count_kept: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (push && full && unit_enable) |=> fill_cnt_reg == 3'h4)
    else $error("full count moved");
  a_ack_one_cycle: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (o_wb_ack && i_ce) |=> !o_wb_ack)
    else $error("ack held too long");
  a_overrun_hold: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (overrun_reg && unit_enable && i_ce && !(rd && hit(i_wb.adr, UBF_OFS_STATUS)))
    |=> overrun_reg) else $error("overrun lost without status read");
  // cover points for the main scenarios
  c_fifo_full: cover property (@(posedge i_core_clk) disable iff (!rst_n) full);
  c_single_wire_tx: cover property (@(posedge i_core_clk) disable iff (!rst_n) o_shared_pin_oe);
  c_held_byte: cover property (@(posedge i_core_clk) disable iff (!rst_n) held_valid_reg);
  c_overrun: cover property (@(posedge i_core_clk) disable iff (!rst_n) overrun_reg);
  c_irq: cover property (@(posedge i_core_clk) disable iff (!rst_n) o_irq);

endmodule : ubf_uart_core

// ===== shared/ubf_pkg.sv
// package for the uart baud, receive fifo and single-wire block
// assumes a wishbone classic slave with 32-bit data, byte registers in the low lane
package ubf_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] UBF_OFS_LINE_MODE = 8'h00;
  localparam logic [7:0] UBF_OFS_DATA      = 8'h04;
  localparam logic [7:0] UBF_OFS_DIV_HIGH  = 8'h08;
  localparam logic [7:0] UBF_OFS_DIV_LOW   = 8'h0c;
  localparam logic [7:0] UBF_OFS_FIFO_MOD  = 8'h10;
  localparam logic [7:0] UBF_OFS_FILL_CNT  = 8'h14;
  localparam logic [7:0] UBF_OFS_CONTROL   = 8'h18;
  localparam logic [7:0] UBF_OFS_STATUS    = 8'h1c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int UBF_LM_SWM_BIT   = 0;
  localparam int UBF_LM_RXINV_BIT = 1;
  localparam int UBF_LM_TXINV_BIT = 2;
  localparam int UBF_FM_TRIG_LSB  = 0;
  localparam int UBF_FM_RANGE_BIT = 2;
  localparam int UBF_FM_MOD_LSB   = 3;
  localparam int UBF_CT_UEN_BIT   = 0;
  localparam int UBF_CT_RECEIVER_ENABLE_BIT_BIT  = 1;
  localparam int UBF_CT_TRANSMITTER_ENABLE_BIT_BIT  = 2;
  localparam int UBF_CT_RIE_BIT   = 3;
  localparam int UBF_ST_RDY_BIT   = 0;
  localparam int UBF_ST_OVR_BIT   = 1;

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [2:0]  UBF_LINE_MODE_RST = 3'h0;
  localparam logic [7:0]  UBF_DIV_RST       = 8'h00;
  localparam logic [5:0]  UBF_FIFO_MOD_RST  = 6'h00;
  localparam logic [3:0]  UBF_CONTROL_RST   = 4'h0;
  localparam int          UBF_FIFO_DEPTH    = 4;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ubf_wb_req_t;

  typedef struct packed {
    logic        tx_invert;
    logic        rx_invert;
    logic        single_wire_enable;
  } ubf_line_mode_t;

  typedef struct packed {
    logic [2:0]  fraction_adjust;
    logic        divisor_range_select;
    logic [1:0]  rx_trigger_level;
  } ubf_fifo_mod_t;

  typedef enum logic [2:0] {
    UBF_RX_IDLE  = 3'b001,
    UBF_RX_START = 3'b010,
    UBF_RX_BITS  = 3'b100
  } ubf_rx_state_t;

endpackage : ubf_pkg

// ===== dv/ubf_remote_uart.sv
// remote uart model that sends frames onto the shared serial line
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps

module ubf_remote_uart (
  input  wire logic i_clk,
  output logic      o_line
);
  initial o_line = 1'b1;

  // ---------------------------------------------------------------
  // line idle level follows the receive inversion setting
  // ---------------------------------------------------------------
  task automatic idle(input logic inv);
    @(posedge i_clk);
    o_line <= ~inv;
  endtask : idle

  // ---------------------------------------------------------------
  // one frame: start, 8 data lsb first, two stop bits
  // ---------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b, input int div, input int frac,
                           input logic inv);
    logic [10:0] fr;
    int          acc;
    int          len;
    fr  = {2'b11, b, 1'b0};
    acc = 0;
    @(posedge i_clk);
    for (int i = 0; i < 11; i++) begin
      acc = acc + frac;
      len = div + (acc >> 3);
      acc = acc & 7;
      o_line <= fr[i] ^ inv;
      repeat (len) @(posedge i_clk);
    end
  endtask : send_byte
endmodule : ubf_remote_uart

// ===== dv/uart_baud_fifo_single_wire_bench.sv
// self-checking bench for the baud, receive fifo and single-wire block
// assumes ubf_pkg, the ubf_uart_core top and the remote uart model
`timescale 1ns/1ps

module uart_baud_fifo_single_wire_bench;
  import ubf_pkg::*;
  logic        i_core_clk;
  logic        i_rst_n;
  logic        i_ce;
  ubf_wb_req_t wb;
  logic        ack, irq, sp_out, sp_oe, tx_pin, remote_line, line;
  logic [31:0] rdat;
  logic [7:0]  v;
  logic [7:0]  bytes [$];
  int          failures, check_count;
  int          cycles = 0;
  int          cur_div, cur_mod, t0;
  logic        cur_inv;
  localparam int LIMIT = 40000;
  int          divs [4] = '{16, 17, 8, 9};
  int          mods [4] = '{7, 3, 0, 5};

  assign line = sp_oe ? sp_out : remote_line;

  ubf_uart_core u_dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_wb(wb),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_shared_pin(line), .o_shared_pin(sp_out),
    .o_shared_pin_oe(sp_oe), .o_transmit_pin(tx_pin), .o_irq(irq)
  );

  ubf_remote_uart u_remote (.i_clk(i_core_clk), .o_line(remote_line));

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  // ---------------------------------------------------------------
  // comparison, bus cycles and receive helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                         output logic [7:0] rd);
    @(posedge i_core_clk);
    wb <= {1'b1, 1'b1, we, adr, 4'h1, 24'h0, wd};
    // request stands until the rising edge that samples ack high
    do begin
      @(posedge i_core_clk);
    end while (ack !== 1'b1);
    rd = rdat[7:0];
    wb <= '0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] x;
    wb_xfer(1'b1, adr, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] x;
    wb_xfer(1'b0, adr, 8'h00, x);
    check({24'h0, x}, {24'h0, exp});
  endtask : rd_chk

  task automatic wait_cnt(input logic [7:0] exp);
    logic [7:0] x;
    int         n;
    n = 0;
    do begin
      wb_xfer(1'b0, UBF_OFS_FILL_CNT, 8'h00, x);
      n++;
    end while (x !== exp && n < 40);
    check({24'h0, x}, {24'h0, exp});
  endtask : wait_cnt

  // unit is disabled while divisor and range change, low byte first
  task automatic setup(input int div, input int md, input logic rs, input logic [1:0] tr);
    cur_div = div;
    cur_mod = md;
    wr(UBF_OFS_CONTROL, 8'h00);
    wr(UBF_OFS_DIV_LOW, 8'(div));
    wr(UBF_OFS_DIV_HIGH, 8'h00);
    wr(UBF_OFS_FIFO_MOD, {2'b00, 3'(md), rs, tr});
    wr(UBF_OFS_CONTROL, 8'h0b);
  endtask : setup

  task automatic rx(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      bytes.push_back(b);
      u_remote.send_byte(b, cur_div, cur_mod, cur_inv);
    end
  endtask : rx

  task automatic drain(input int n);
    repeat (n) rd_chk(UBF_OFS_DATA, bytes.pop_front());
  endtask : drain

  function automatic logic ready_exp(input int code, input int cnt);
    return cnt >= ((code == 0) ? 4 : code);
  endfunction : ready_exp

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    wb = '0;
    i_ce = 1'b1;
    i_rst_n = 1'b0;
    cur_inv = 1'b0;
    failures = 0;
    check_count = 0;
    void'($urandom(49));
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd_chk(UBF_OFS_LINE_MODE, 8'h00);
    rd_chk(UBF_OFS_DIV_HIGH, 8'h00);
    rd_chk(UBF_OFS_DIV_LOW, 8'h00);
    rd_chk(UBF_OFS_FIFO_MOD, 8'h00);
    rd_chk(UBF_OFS_FILL_CNT, 8'h00);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
    check({31'h0, tx_pin}, 32'h1);
    repeat (8) begin
      v = 8'($urandom);
      wr(UBF_OFS_LINE_MODE, v);
      wr(UBF_OFS_FIFO_MOD, v);
      rd_chk(UBF_OFS_LINE_MODE, {5'h0, v[2:0]});
      check({31'h0, tx_pin}, {31'h0, ~v[2]});
      check({31'h0, sp_out}, {31'h0, ~v[2]});
      rd_chk(UBF_OFS_FIFO_MOD, {2'h0, v[5:0]});
      wr(UBF_OFS_DIV_LOW, v);
      wr(UBF_OFS_DIV_HIGH, ~v);
      rd_chk(UBF_OFS_DIV_LOW, v);
      rd_chk(UBF_OFS_DIV_HIGH, ~v);
    end
    wr(UBF_OFS_LINE_MODE, 8'h00);
    $display("test registers done");
    for (int code = 0; code < 4; code++) begin
      setup(16, 7, 1'b0, 2'(code));
      wait_cnt(8'h00);
      for (int k = 1; k <= 4; k++) begin
        rx(1);
        wait_cnt(8'(k));
        rd_chk(UBF_OFS_STATUS, {7'h0, ready_exp(code, k)});
        check({31'h0, irq}, {31'h0, ready_exp(code, k)});
      end
      drain(4);
      wait_cnt(8'h00);
    end
    $display("test trigger done");
    setup(17, 3, 1'b0, 2'd1);
    rx(5);
    wait_cnt(8'h04);
    rd_chk(UBF_OFS_STATUS, 8'h01);
    rx(1);
    rd_chk(UBF_OFS_STATUS, 8'h03);
    check({31'h0, irq}, 32'h1);
    rd_chk(UBF_OFS_STATUS, 8'h01);
    wr(UBF_OFS_CONTROL, 8'h03);
    rd_chk(UBF_OFS_CONTROL, 8'h03);
    check({31'h0, irq}, 32'h0);
    bytes.delete(4);
    drain(1);
    wait_cnt(8'h04);
    drain(4);
    wait_cnt(8'h00);
    $display("test overrun done");
    wr(UBF_OFS_CONTROL, 8'h0b);
    rx(2);
    wait_cnt(8'h02);
    // the disabling write waits while the clock enable is held low
    i_ce <= 1'b0;
    fork
      begin
        repeat (10) @(posedge i_core_clk);
        i_ce <= 1'b1;
      end
    join_none
    t0 = cycles;
    wr(UBF_OFS_CONTROL, 8'h00);
    check({31'h0, (cycles - t0) > 10}, 32'h1);
    wait_cnt(8'h00);
    rd_chk(UBF_OFS_DIV_LOW, 8'd17);
    rd_chk(UBF_OFS_FIFO_MOD, 8'h19);
    wr(UBF_OFS_CONTROL, 8'h0b);
    rd_chk(UBF_OFS_STATUS, 8'h00);
    bytes.delete();
    $display("test disable done");
    // divisors at the bottom of each range; 17 with 3 is the worked example
    for (int i = 0; i < 4; i++) begin
      setup(divs[i], mods[i], i[1], 2'd1);
      rx(3);
      wait_cnt(8'h03);
      drain(3);
    end
    setup(12 + ($urandom % 20), $urandom % 8, 1'b1, 2'd1);
    rx(2);
    wait_cnt(8'h02);
    drain(2);
    $display("test baud done");
    wr(UBF_OFS_CONTROL, 8'h00);
    wr(UBF_OFS_LINE_MODE, 8'h02);
    cur_inv = 1'b1;
    u_remote.idle(1'b1);
    setup(16, 0, 1'b0, 2'd1);
    rx(2);
    wait_cnt(8'h02);
    drain(2);
    wr(UBF_OFS_CONTROL, 8'h00);
    wr(UBF_OFS_LINE_MODE, 8'h00);
    cur_inv = 1'b0;
    u_remote.idle(1'b0);
    $display("test invert done");
    for (int m = 0; m < 8; m++) begin
      wr(UBF_OFS_LINE_MODE, {7'h0, m[0]});
      wr(UBF_OFS_CONTROL, {5'h0, m[2:1], 1'b1});
      rd_chk(UBF_OFS_CONTROL, {5'h0, m[2:1], 1'b1});
      check({31'h0, sp_oe}, {31'h0, m[0] & m[2] & ~m[1]});
      check({31'h0, sp_out}, 32'h1);
    end
    wr(UBF_OFS_CONTROL, 8'h00);
    wr(UBF_OFS_LINE_MODE, 8'h00);
    $display("test single_wire done");
    test_done();
  end
endmodule : uart_baud_fifo_single_wire_bench
